// file: core/ads_device.sv
// Converter alignment, sequencing and fault flag logic
//
// Added by the designer: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module ads_device
  import ads_pkg::*;
#(
  parameter int          CONV_CYCLES = CONV_CYCLES_DEF,
  parameter logic [15:0] ID_CODE     = ID_DEF
) (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Link to host
  ads_link_if.dev          link,
  // Modulator result
  input  wire logic [23:0] conv_value,
  input  wire logic        conv_over,
  input  wire logic        conv_under,
  // Engine state
  output logic             mod_reset_q,
  output logic             sampling_q,
  output logic [3:0]       chan_q,
  output logic             drive_boost_q
);
  typedef enum logic [1:0] {
    ST_RUN  = 2'b00,
    ST_WAIT = 2'b01,
    ST_HOLD = 2'b10
  } ads_state_type;

  ads_state_type st_q;
  logic [15:0] ifmode_q, pinctl_q, chmask_q;
  logic [23:0] data_q, ref_q, cks;
  logic [3:0]  res_chan_q;
  logic [31:0] cnt_q, rdata_q;
  logic        align_s, req_s, fault_s;
  logic        range_cond_q, crc_err_q, cfg_err_q, drdy_n_q, ack_q;
  logic        fault_o_q, fault_oe_q;
  logic        align_on, stepwise, align_low, hold, done;
  logic        range_err, acc, wr_ok, wr_bad, rd_status, rd_data;
  logic [1:0]  fault_fn;
  logic [7:0]  status;

  ads_sync #(.W(3), .RSTV(3'b101)) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       ({link.align_n, link.req, link.fault_lvl}),
    .q       ({align_s, req_s, fault_s})
  );

  // Next enabled channel after c, wrapping; stays put when none is enabled
  function automatic logic [3:0] next_ch(input logic [15:0] m,
                                         input logic [3:0]  c);
    logic [3:0] r;
    logic [3:0] idx;
    r = c;
    for (int i = 16; i >= 1; i--) begin
      idx = c + i[3:0];
      if (m[idx]) r = idx;
    end
    return r;
  endfunction

  assign fault_fn  = pinctl_q[FAULT_FN_LSB +: 2];
  assign align_on  = pinctl_q[ALIGN_EN_BIT];
  assign stepwise  = align_on && ifmode_q[STEPWISE_BIT];
  assign align_low = align_on && !align_s;
  assign hold      = align_low && !stepwise;
  assign done      = (st_q == ST_RUN) && !hold &&
                     (cnt_q == 32'(CONV_CYCLES - 1));

  // Sequencer and conversion timing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q        <= ST_RUN;
      cnt_q       <= '0;
      chan_q      <= '0;
      mod_reset_q <= 1'b0;
      sampling_q  <= 1'b0;
    end else begin
      mod_reset_q <= hold;
      sampling_q  <= 1'b0;
      if (hold) begin
        // Configuration registers are left untouched here
        st_q   <= ST_HOLD;
        cnt_q  <= '0;
        chan_q <= next_ch(chmask_q, 4'hf);
      end else begin
        case (st_q)
          ST_HOLD: begin
            st_q <= ST_RUN;
          end
          ST_RUN: begin
            sampling_q <= 1'b1;
            if (done) begin
              cnt_q  <= '0;
              chan_q <= next_ch(chmask_q, chan_q);
              if (stepwise && align_low) st_q <= ST_WAIT;
            end else begin
              cnt_q <= cnt_q + 32'd1;
            end
          end
          ST_WAIT: begin
            if (!align_low) st_q <= ST_RUN;
          end
          default: st_q <= ST_RUN;
        endcase
      end
    end
  end

  // Result register and ready flag
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      data_q       <= '0;
      res_chan_q   <= '0;
      range_cond_q <= 1'b0;
      drdy_n_q     <= STATUS_RST[7];
    end else if (done) begin
      // Result moves only at completion, never mid-conversion
      data_q       <= conv_over  ? 24'hffffff :
                      conv_under ? 24'h000000 : conv_value;
      range_cond_q <= conv_over || conv_under;
      res_chan_q   <= chan_q;
      drdy_n_q     <= 1'b0;
    end else if (rd_data) begin
      drdy_n_q <= 1'b1;
    end
  end

  // Register access handshake
  assign acc       = req_s && !ack_q;
  assign cks       = {16'h0000, link.acc_addr} ^ link.acc_wdata;
  assign wr_ok     = acc && link.acc_wr &&
                     (cks[7:0] ^ cks[15:8] ^ cks[23:16]) == link.acc_cks;
  assign wr_bad    = acc && link.acc_wr && !wr_ok;
  assign rd_status = acc && !link.acc_wr && link.acc_addr == REG_STATUS;
  assign rd_data   = acc && !link.acc_wr && link.acc_addr == REG_DATA;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ifmode_q <= IFMODE_RST;
      pinctl_q <= PINCTL_RST;
      chmask_q <= CHMASK_RST;
    end else if (wr_ok) begin
      case (link.acc_addr)
        REG_IFMODE: ifmode_q <= link.acc_wdata[15:0];
        REG_PINCTL: pinctl_q <= link.acc_wdata[15:0];
        REG_CHMASK: chmask_q <= link.acc_wdata[15:0];
        default:    ;
      endcase
    end
  end

  // Fault flags
  assign range_err = range_cond_q || (fault_fn == FN_IN && !fault_s);
  assign status    = {drdy_n_q, range_err, crc_err_q, cfg_err_q,
                      res_chan_q};
  // Interface mode, status and result stay out of the checksum
  logic [23:0] watch_sum;
  assign watch_sum = {pinctl_q, 8'h00} ^ {8'h00, chmask_q};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      crc_err_q <= 1'b0;
      cfg_err_q <= 1'b0;
      ref_q     <= '0;
    end else begin
      if (wr_bad) crc_err_q <= 1'b1;
      else if (rd_status) crc_err_q <= 1'b0;
      if (!ifmode_q[WATCH_BIT]) begin
        ref_q     <= watch_sum;
        cfg_err_q <= 1'b0;
      end else if (watch_sum != ref_q) begin
        cfg_err_q <= 1'b1;
      end
    end
  end

  // Read data and acknowledge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ack_q   <= 1'b0;
      rdata_q <= '0;
    end else begin
      if (!req_s) ack_q <= 1'b0;
      else if (acc) ack_q <= 1'b1;
      if (acc && !link.acc_wr) begin
        case (link.acc_addr)
          REG_STATUS: rdata_q <= {24'h0, status};
          REG_IFMODE: rdata_q <= {16'h0, ifmode_q};
          REG_CHECK:  rdata_q <= {8'h0, ref_q};
          REG_DATA:   rdata_q <= ifmode_q[APPEND_BIT] ?
                                 {data_q, status} : {8'h0, data_q};
          REG_PINCTL: rdata_q <= {16'h0, pinctl_q[15:9],
                                  fault_fn == FN_IN ? fault_s :
                                  pinctl_q[FAULT_LVL_BIT],
                                  pinctl_q[7:0]};
          REG_ID:     rdata_q <= {16'h0, ID_CODE};
          REG_CHMASK: rdata_q <= {16'h0, chmask_q};
          default:    rdata_q <= '0;
        endcase
      end
    end
  end

  // Fault pin driver
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fault_o_q     <= 1'b1;
      fault_oe_q    <= 1'b0;
      drive_boost_q <= 1'b0;
    end else begin
      drive_boost_q <= ifmode_q[BOOST_BIT];
      case (fault_fn)
        FN_OUT: begin
          fault_o_q  <= 1'b0;
          fault_oe_q <= range_err || crc_err_q || cfg_err_q;
        end
        FN_GPO: begin
          fault_o_q  <= pinctl_q[FAULT_LVL_BIT];
          fault_oe_q <= 1'b1;
        end
        default: begin
          fault_o_q  <= 1'b1;
          fault_oe_q <= 1'b0;
        end
      endcase
    end
  end

  assign link.ack       = ack_q;
  assign link.acc_rdata = rdata_q;
  assign link.drdy_n    = drdy_n_q;
  assign link.fault_o   = fault_o_q;
  assign link.fault_oe  = fault_oe_q;
endmodule

// file: core/ads_pkg.sv
// Shared constants for the converter alignment and fault control link
package ads_pkg;
  // Device register addresses
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_IFMODE = 8'h02;
  localparam logic [7:0] REG_CHECK  = 8'h03;
  localparam logic [7:0] REG_DATA   = 8'h04;
  localparam logic [7:0] REG_PINCTL = 8'h06;
  localparam logic [7:0] REG_ID     = 8'h07;
  localparam logic [7:0] REG_CHMASK = 8'h10;
  // Reset values
  localparam logic [15:0] IFMODE_RST = 16'h0000;
  localparam logic [15:0] PINCTL_RST = 16'h0800;
  localparam logic [15:0] CHMASK_RST = 16'h0001;
  localparam logic [7:0]  STATUS_RST = 8'h80;
  // Interface mode fields
  localparam int STEPWISE_BIT = 12;
  localparam int BOOST_BIT    = 11;
  localparam int APPEND_BIT   = 6;
  localparam int WATCH_BIT    = 5;
  // Pin control fields
  localparam int ALIGN_EN_BIT = 11;
  localparam int FAULT_FN_LSB = 9;
  localparam int FAULT_LVL_BIT = 8;
  localparam logic [1:0] FN_OFF   = 2'h0;
  localparam logic [1:0] FN_IN    = 2'h1;
  localparam logic [1:0] FN_OUT   = 2'h2;
  localparam logic [1:0] FN_GPO   = 2'h3;
  // Arbitrary identity value
  localparam logic [15:0] ID_DEF  = 16'h5a00;
  localparam int CONV_CYCLES_DEF  = 32;
  // Host AXI4-Lite register byte offsets
  localparam logic [4:0] H_CTRL   = 5'h00;
  localparam logic [4:0] H_ACC    = 5'h04;
  localparam logic [4:0] H_WDATA  = 5'h08;
  localparam logic [4:0] H_RDATA  = 5'h0c;
  localparam logic [4:0] H_STAT   = 5'h10;
  localparam int CTRL_ALIGN_LOW   = 0;
  localparam int CTRL_BAD_CKS     = 1;
  localparam int ACC_RD_BIT       = 8;
  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
endpackage

// file: core/ads_link_if.sv
// Pins between the converter control and its host controller
`timescale 1ns/1ps
interface ads_link_if;
  logic        align_n;
  logic        req;
  logic        ack;
  logic        acc_wr;
  logic [7:0]  acc_addr;
  logic [23:0] acc_wdata;
  logic [7:0]  acc_cks;
  logic [31:0] acc_rdata;
  logic        drdy_n;
  logic        fault_o;
  logic        fault_oe;
  logic        fault_lvl;
  logic        ext_fault_n;

  // Pull-up on the fault wire; another part sharing it may pull it low
  assign fault_lvl = (fault_oe ? fault_o : 1'b1) && ext_fault_n;

  modport dev (input align_n, req, acc_wr, acc_addr, acc_wdata, acc_cks,
               fault_lvl, output ack, acc_rdata, drdy_n, fault_o, fault_oe);
  modport host (output align_n, req, acc_wr, acc_addr, acc_wdata, acc_cks,
                input ack, acc_rdata, drdy_n, fault_lvl);
endinterface

// file: core/ads_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module ads_sync #(
  parameter int         W    = 1,
  parameter logic [W-1:0] RSTV = '0
) (
  // Clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // Data
  input  wire logic [W-1:0] d,
  output logic [W-1:0]      q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= RSTV;
      q      <= RSTV;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule

// file: core/ads_host.sv
// Host controller: AXI4-Lite registers driving the alignment link
`timescale 1ns/1ps
module ads_host
  import ads_pkg::*;
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Link to device
  ads_link_if.host         link,
  // AXI4-Lite write
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [4:0]  awaddr,
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  output logic             bvalid,
  input  wire logic        bready,
  output logic [1:0]       bresp,
  // AXI4-Lite read
  input  wire logic        arvalid,
  output logic             arready,
  input  wire logic [4:0]  araddr,
  output logic             rvalid,
  input  wire logic        rready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp
);
  typedef enum logic [1:0] {
    HS_IDLE = 2'b00,
    HS_REQ  = 2'b01,
    HS_DONE = 2'b10
  } ads_hstate_type;

  ads_hstate_type hs_q;
  logic [4:0]  wa_q;
  logic [31:0] wd_q, ctrl_q, wval_q, rd_q, mask;
  logic [8:0]  acc_q;
  logic        aw_have_q, w_have_q, ack_s, drdy_s, fault_s;
  logic        req_q, launch, wmap;

  ads_sync #(.W(3), .RSTV(3'b011)) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       ({link.ack, link.drdy_n, link.fault_lvl}),
    .q       ({ack_s, drdy_s, fault_s})
  );

  assign mask = {{8{wstrb[3]}}, {8{wstrb[2]}}, {8{wstrb[1]}}, {8{wstrb[0]}}};
  assign wmap = wa_q == H_CTRL || wa_q == H_ACC || wa_q == H_WDATA;
  // Starting an access while one runs is ignored
  assign launch = aw_have_q && w_have_q && !bvalid && wa_q == H_ACC &&
                  hs_q == HS_IDLE;

  // Write channels: address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready   <= 1'b1;
      wready    <= 1'b1;
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      bvalid    <= 1'b0;
      bresp     <= RESP_OK;
      wa_q      <= '0;
      wd_q      <= '0;
    end else begin
      if (awvalid && awready) begin
        awready   <= 1'b0;
        aw_have_q <= 1'b1;
        wa_q      <= awaddr;
      end
      if (wvalid && wready) begin
        wready   <= 1'b0;
        w_have_q <= 1'b1;
        wd_q     <= wdata & mask;
      end
      if (aw_have_q && w_have_q && !bvalid) begin
        bvalid <= 1'b1;
        bresp  <= wmap ? RESP_OK : RESP_ERR;
      end
      if (bvalid && bready) begin
        bvalid    <= 1'b0;
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
        awready   <= 1'b1;
        wready    <= 1'b1;
      end
    end
  end

  // Host registers; the strobe mask was applied when data was taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= '0;
      wval_q <= '0;
      acc_q  <= '0;
    end else if (aw_have_q && w_have_q && !bvalid) begin
      if (wa_q == H_CTRL)  ctrl_q <= wd_q;
      if (wa_q == H_WDATA) wval_q <= wd_q;
      if (launch)          acc_q  <= wd_q[8:0];
    end
  end

  // Four-phase access toward the device
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hs_q  <= HS_IDLE;
      req_q <= 1'b0;
      rd_q  <= '0;
    end else begin
      case (hs_q)
        HS_IDLE: if (launch) begin
          hs_q  <= HS_REQ;
          req_q <= 1'b1;
        end
        HS_REQ: if (ack_s) begin
          // Device holds read data stable while ack is high
          if (acc_q[ACC_RD_BIT]) rd_q <= link.acc_rdata;
          hs_q  <= HS_DONE;
          req_q <= 1'b0;
        end
        HS_DONE: if (!ack_s) hs_q <= HS_IDLE;
        default: hs_q <= HS_IDLE;
      endcase
    end
  end

  // Read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= RESP_OK;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rresp   <= RESP_OK;
      case (araddr)
        H_CTRL:  rdata <= ctrl_q;
        H_ACC:   rdata <= {23'h0, acc_q};
        H_WDATA: rdata <= wval_q;
        H_RDATA: rdata <= rd_q;
        H_STAT:  rdata <= {28'h0, fault_s, drdy_s, 1'b0, hs_q != HS_IDLE};
        default: begin
          rdata <= '0;
          rresp <= RESP_ERR;
        end
      endcase
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end

  logic [23:0] cks;
  assign cks = {16'h0000, acc_q[7:0]} ^ wval_q[23:0];

  // Link pins, all from flops
  logic       align_n_q, wr_q;
  logic [7:0] cks_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      align_n_q <= 1'b1;
      wr_q      <= 1'b0;
      cks_q     <= '0;
    end else begin
      align_n_q <= !ctrl_q[CTRL_ALIGN_LOW];
      wr_q      <= !acc_q[ACC_RD_BIT];
      cks_q     <= cks[7:0] ^ cks[15:8] ^ cks[23:16] ^
                   {7'h0, ctrl_q[CTRL_BAD_CKS]};
    end
  end

  assign link.align_n   = align_n_q;
  assign link.req       = req_q;
  assign link.acc_wr    = wr_q;
  assign link.acc_addr  = acc_q[7:0];
  assign link.acc_wdata = wval_q[23:0];
  assign link.acc_cks   = cks_q;
endmodule

// file: tb/ads_link_monitor.sv
// Checker for the alignment and fault link between device and host
`timescale 1ns/1ps
module ads_link_monitor
  import ads_pkg::*;
#(
  parameter int CONV_CYCLES = CONV_CYCLES_DEF
) (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Link
  input wire logic        align_n,
  input wire logic        req,
  input wire logic        ack,
  input wire logic        acc_wr,
  input wire logic [7:0]  acc_addr,
  input wire logic [23:0] acc_wdata,
  input wire logic [7:0]  acc_cks,
  input wire logic        drdy_n,
  input wire logic        fault_o,
  input wire logic        fault_oe
);
  localparam int LO   = CONV_CYCLES + 1;
  localparam int HI   = CONV_CYCLES + 6;
  localparam int STEP = CONV_CYCLES + 8;
  logic       ack_q;
  logic       al_q;
  logic       first_q;
  logic       en_q;
  logic       step_q;
  logic       lvl_q;
  logic [1:0] fn_q;
  logic [7:0] cnt_q;
  logic       cks_ok;

  assign cks_ok = acc_cks == (acc_addr ^ acc_wdata[23:16] ^
                              acc_wdata[15:8] ^ acc_wdata[7:0]);

  always_ff @(posedge aclk) begin
    ack_q <= aresetn && ack;
  end

  // Shadow of the mode bits, taken from accepted writes only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      en_q   <= PINCTL_RST[ALIGN_EN_BIT];
      fn_q   <= PINCTL_RST[FAULT_FN_LSB +: 2];
      lvl_q  <= PINCTL_RST[FAULT_LVL_BIT];
      step_q <= IFMODE_RST[STEPWISE_BIT];
    end else if (ack && !ack_q && acc_wr && cks_ok) begin
      if (acc_addr == REG_PINCTL) begin
        en_q  <= acc_wdata[ALIGN_EN_BIT];
        fn_q  <= acc_wdata[FAULT_FN_LSB +: 2];
        lvl_q <= acc_wdata[FAULT_LVL_BIT];
      end
      if (acc_addr == REG_IFMODE) begin
        step_q <= acc_wdata[STEPWISE_BIT];
      end
    end
  end

  // Cycles since the pin last changed; only long pulses arm the
  // restart window, a short glitch may legally race a completion
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      al_q    <= 1'b1;
      cnt_q   <= 8'h00;
      first_q <= 1'b0;
    end else begin
      al_q <= align_n;
      if (align_n != al_q) begin
        cnt_q   <= 8'h00;
        first_q <= !al_q && en_q && !step_q && drdy_n && cnt_q >= 8'h06;
      end else begin
        cnt_q   <= (cnt_q == 8'hff) ? cnt_q : cnt_q + 8'h01;
        first_q <= first_q && drdy_n;
      end
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_ALIGN_MIN: assert property (
    $fell(align_n) |=> !align_n) else $error("alignment pulse too short");
  AST_HOLD_NO_DRDY: assert property (
    !align_n && en_q && !step_q && cnt_q >= 8'h05 |-> !$fell(drdy_n))
    else $error("result completed while held");
  AST_RESTART_EARLY: assert property (
    first_q && !drdy_n |-> cnt_q >= LO)
    else $error("result too soon after release");
  AST_RESTART_LATE: assert property (
    first_q |-> cnt_q <= HI) else $error("result late after release");
  AST_STEP_WAIT: assert property (
    !align_n && en_q && step_q && cnt_q >= STEP |-> !$fell(drdy_n))
    else $error("stepwise converted while pin low");
  AST_OD_LOW: assert property (
    fn_q == FN_OUT && $past(fn_q, 2) == FN_OUT |-> !fault_oe || !fault_o)
    else $error("open-drain pin drove high");
  AST_PIN_OFF: assert property (
    (fn_q == FN_OFF || fn_q == FN_IN) && $past(fn_q, 2) == fn_q
    |-> !fault_oe) else $error("fault pin driven while off or input");
  AST_GPO_LEVEL: assert property (
    fn_q == FN_GPO && $past(fn_q, 2) == FN_GPO && $stable(lvl_q)
    |-> fault_oe && fault_o == lvl_q) else $error("output level wrong");
  AST_ACK_WITH_REQ: assert property (
    $rose(ack) |-> req) else $error("acknowledge without request");

  cover property (first_q && !drdy_n);
  cover property (fn_q == FN_OUT && fault_oe);
  cover property (step_q && !align_n && $fell(drdy_n));
endmodule

// file: tb/adc_sync_and_fault_logic_test.sv
// Self-checking bench for the converter alignment and fault link
`timescale 1ns/1ps
`define CHK(g, e) begin \
  comparisons++; \
  if ((g) !== (e)) begin \
    err_total++; \
    $display("[ERR] t=%0t got %h exp %h", $time, (g), (e)); \
  end \
end
module adc_sync_and_fault_logic_test;
  import ads_pkg::*;
  localparam int CONV = 4;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [4:0] awaddr = 5'h00, araddr = 5'h00;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic [1:0] bresp, rresp, resp;
  logic [23:0] conv_value = 24'h0;
  logic conv_over = 1'b0, conv_under = 1'b0;
  logic mod_reset_q, sampling_q, drive_boost_q;
  logic [3:0] chan_q;
  int err_total = 0, comparisons = 0, cycles = 0;

  always #2.5 aclk = ~aclk;
  ads_link_if link();
  ads_device #(.CONV_CYCLES(CONV), .ID_CODE(16'h5a00)) i_ads_device (
    .aclk(aclk), .aresetn(aresetn), .link(link),
    .conv_value(conv_value), .conv_over(conv_over),
    .conv_under(conv_under), .mod_reset_q(mod_reset_q),
    .sampling_q(sampling_q), .chan_q(chan_q),
    .drive_boost_q(drive_boost_q));
  ads_host i_ads_host (
    .aclk(aclk), .aresetn(aresetn), .link(link),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hf),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp));
  ads_link_monitor #(.CONV_CYCLES(CONV)) i_mon (
    .aclk(aclk), .aresetn(aresetn), .align_n(link.align_n),
    .req(link.req), .ack(link.ack), .acc_wr(link.acc_wr),
    .acc_addr(link.acc_addr), .acc_wdata(link.acc_wdata),
    .acc_cks(link.acc_cks), .drdy_n(link.drdy_n),
    .fault_o(link.fault_o), .fault_oe(link.fault_oe));

  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Whole run needs roughly a thousand cycles
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      results();
    end
  end

  task automatic axi_wr(input logic [4:0] a, input logic [31:0] d);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && awready) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!bvalid);
    resp = bresp;
    bready <= 1'b0;
    // One idle edge so a following call never re-raises bready at once
    @(posedge aclk);
  endtask

  task automatic axi_rd(input logic [4:0] a, output logic [31:0] d);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic dev_wait;
    logic [31:0] s;
    s = 32'h1;
    while (s[0]) axi_rd(H_STAT, s);
  endtask

  task automatic dev_wr(input logic [7:0] a, input logic [23:0] d);
    axi_wr(H_WDATA, {8'h00, d});
    axi_wr(H_ACC, {24'h0, a});
    dev_wait();
  endtask

  task automatic dev_rd(input logic [7:0] a, output logic [31:0] d);
    axi_wr(H_ACC, {23'h0, 1'b1, a});
    dev_wait();
    axi_rd(H_RDATA, d);
  endtask

  // Clears the ready flag, then waits for a fresh completion
  task automatic wait_conv;
    int n;
    dev_rd(REG_DATA, rd);
    n = 0;
    while (link.drdy_n !== 1'b0 && n < 400) begin
      @(posedge aclk);
      n++;
    end
    `CHK(link.drdy_n, 1'b0)
  endtask

  task automatic t_reset;
    dev_rd(REG_PINCTL, rd);
    `CHK(rd[15:0], PINCTL_RST)
    dev_rd(REG_IFMODE, rd);
    `CHK(rd[15:0], IFMODE_RST)
    dev_rd(REG_STATUS, rd);
    `CHK(rd[6:0], STATUS_RST[6:0])
    `CHK(rd[7], 1'b0)
    axi_wr(5'h14, 32'h1);
    `CHK(resp, RESP_ERR)
    axi_rd(5'h14, rd);
    `CHK(resp, RESP_ERR)
    $display("test reset done");
  endtask

  task automatic t_sync;
    dev_wr(REG_CHMASK, 24'h000006);
    wait_conv();
    axi_wr(H_CTRL, 32'h1);
    repeat (8) @(posedge aclk);
    `CHK(mod_reset_q, 1'b1)
    `CHK(chan_q, 4'h1)
    dev_rd(REG_CHMASK, rd);
    `CHK(rd[15:0], 16'h0006)
    `CHK(sampling_q, 1'b0)
    // Clear the ready flag while held so the release arms the monitor
    dev_rd(REG_DATA, rd);
    axi_wr(H_CTRL, 32'h0);
    wait_conv();
    `CHK(mod_reset_q, 1'b0)
    dev_wr(REG_PINCTL, 24'h000000);
    axi_wr(H_CTRL, 32'h1);
    repeat (8) @(posedge aclk);
    `CHK(mod_reset_q, 1'b0)
    axi_wr(H_CTRL, 32'h0);
    dev_wr(REG_PINCTL, 24'h000800);
    $display("test sync done");
  endtask

  task automatic t_range;
    conv_over <= 1'b1;
    conv_value <= 24'h123456;
    wait_conv();
    dev_rd(REG_DATA, rd);
    `CHK(rd, 32'h00ffffff)
    dev_rd(REG_STATUS, rd);
    `CHK(rd[6], 1'b1)
    dev_rd(REG_STATUS, rd);
    `CHK(rd[6], 1'b1)
    conv_over <= 1'b0;
    conv_under <= 1'b1;
    wait_conv();
    dev_rd(REG_DATA, rd);
    `CHK(rd, 32'h00000000)
    conv_under <= 1'b0;
    wait_conv();
    dev_rd(REG_DATA, rd);
    `CHK(rd, 32'h00123456)
    dev_rd(REG_STATUS, rd);
    `CHK(rd[6], 1'b0)
    $display("test range done");
  endtask

  task automatic t_fault;
    dev_wr(REG_PINCTL, 24'h000c00);
    `CHK(link.fault_lvl, 1'b1)
    axi_wr(H_CTRL, 32'h2);
    dev_wr(REG_IFMODE, 24'h000800);
    axi_wr(H_CTRL, 32'h0);
    `CHK(link.fault_lvl, 1'b0)
    `CHK(drive_boost_q, 1'b0)
    dev_rd(REG_STATUS, rd);
    `CHK(rd[5], 1'b1)
    dev_rd(REG_STATUS, rd);
    `CHK(rd[5], 1'b0)
    `CHK(link.fault_lvl, 1'b1)
    dev_wr(REG_PINCTL, 24'h000e00);
    `CHK(link.fault_lvl, 1'b0)
    dev_wr(REG_PINCTL, 24'h000f00);
    `CHK(link.fault_lvl, 1'b1)
    dev_wr(REG_PINCTL, 24'h000800);
    `CHK(link.fault_oe, 1'b0)
    dev_wr(REG_PINCTL, 24'h000a00);
    dev_rd(REG_PINCTL, rd);
    `CHK(rd[8], 1'b1)
    dev_rd(REG_STATUS, rd);
    `CHK(rd[6], 1'b0)
    link.ext_fault_n <= 1'b0;
    dev_rd(REG_PINCTL, rd);
    `CHK(rd[8], 1'b0)
    dev_rd(REG_STATUS, rd);
    `CHK(rd[6], 1'b1)
    axi_rd(H_STAT, rd);
    `CHK(rd[3], 1'b0)
    link.ext_fault_n <= 1'b1;
    $display("test fault pin done");
  endtask

  task automatic t_watch;
    dev_wr(REG_IFMODE, 24'h000020);
    dev_wr(REG_IFMODE, 24'h000820);
    dev_rd(REG_STATUS, rd);
    `CHK(rd[4], 1'b0)
    `CHK(drive_boost_q, 1'b1)
    dev_wr(REG_CHMASK, 24'h000005);
    dev_rd(REG_STATUS, rd);
    `CHK(rd[4], 1'b1)
    dev_wr(REG_IFMODE, 24'h000000);
    dev_rd(REG_STATUS, rd);
    `CHK(rd[4], 1'b0)
    $display("test watch done");
  endtask

  task automatic t_step;
    dev_wr(REG_IFMODE, 24'h001000);
    axi_wr(H_CTRL, 32'h1);
    // The running conversion finishes, then the engine parks
    repeat (10) @(posedge aclk);
    `CHK(link.drdy_n, 1'b0)
    dev_rd(REG_DATA, rd);
    repeat (30) @(posedge aclk);
    `CHK(sampling_q, 1'b0)
    `CHK(link.drdy_n, 1'b1)
    dev_rd(REG_STATUS, rd);
    `CHK(rd[3:0] ^ chan_q, 4'h2)
    axi_wr(H_CTRL, 32'h0);
    wait_conv();
    dev_wr(REG_IFMODE, 24'h000040);
    wait_conv();
    dev_rd(REG_DATA, rd);
    `CHK(rd[31:8], 24'h123456)
    `CHK(rd[3:0] & 4'hd, 4'h0)
    $display("test stepwise done");
  endtask

  initial begin
    link.ext_fault_n <= 1'b1;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_sync();
    t_range();
    t_fault();
    t_watch();
    t_step();
    results();
  end
endmodule
